// >>> include/pgfc_defs.vh
/*
 * pgfc_defs.vh - register map, field positions, reset values and timing
 * counts of the amplifier fault, pin and input switch control block.
 * Assumes a 100 MHz system clock; included by bare name.
 */
`ifndef PGFC_DEFS_VH
`define PGFC_DEFS_VH

// register addresses on the serial port
`define PGFC_ADDR_ANALOG_ERR   7'h04
`define PGFC_ADDR_PIN_DATA     7'h05
`define PGFC_ADDR_INPUT_SW     7'h06
`define PGFC_ADDR_WIRE_BREAK   7'h07
`define PGFC_ADDR_PIN_DIR      7'h08
`define PGFC_ADDR_SEQ_SELECT   7'h09

// reset values
`define PGFC_RST_PIN_DATA      7'h00
`define PGFC_RST_INPUT_SW      7'h60
`define PGFC_RST_WIRE_BREAK    8'h02
`define PGFC_RST_PIN_DIR       7'h00
`define PGFC_RST_SEQ_SELECT    7'h00

// analog error flag bit positions
`define PGFC_BIT_GAIN_RST      7
`define PGFC_BIT_OUT_OVL       2
`define PGFC_BIT_IN_OVL        1
`define PGFC_BIT_MUX_OV        0

// wire break register fields
`define PGFC_BIT_WB_GAIN_DIS   7
`define PGFC_BIT_WB_SW_FIRST   3
`define PGFC_BIT_WB_SW_SECOND  2

// serial frame: one header byte then one data byte
`define PGFC_FRAME_BITS        5'd16
`define PGFC_HDR_BITS          5'd8

// sequencer slot that addresses this device itself
`define PGFC_SLOT_SELF         3'h7

// timing
`define PGFC_CLK_MHZ           100
`define PGFC_IOVL_TIME_US      200
// counts are time times clock rate, sized to the counters they load
`define PGFC_IOVL_CYC          16'd20000
`define PGFC_RESTORE_TIME_US   20
`define PGFC_RESTORE_CYC       12'd2000

`endif

// >>> rtl/pgfc_ctrl.v
/*
 * pgfc_ctrl - control register logic of the amplifier front end: fault
 * flags, gain reset, mux overvoltage protect and restore, seven pins,
 * input switches, wire break test and sequential chip select.
 * Assumes a host serial port (mode 0, 16-bit frames) and analog
 * condition levels that are asynchronous to clk_sys.
 */
// What this block does
// RL1 - output overload flag sets, write-one clears
// RL2 - input overload flag sets, write-one clears
// RL3 - long input overload resets gain, sets flag
// RL4 - overvoltage sets flag, opens all input switches
// RL5 - restore switches after 20 us in range
// RL6 - nonlatched overvoltage flag clears at restore
// RL7 - output pins drive their data bits
// RL8 - input pins read pin level, ignore writes
// RL9 - switch bits close switches; channel one default
// RL10 - channel pairs exclusive unless protection disabled
// RL11 - test path bits connect test mux
// RL12 - short bit ties amplifier inputs together
// RL13 - wire break switches close, both allowed
// RL14 - wire break forces default gain, readback kept
// RL15 - override disable keeps programmed gain
// RL16 - two-bit field selects break current
// RL17 - direction bit one means output; reset inputs
// RL18 - selected output pins become chip selects
// RL19 - host pulses rotate through pins, then device
// RL20 - ascending order, restart on map write
// RL21 - host counts its own chip-select pulses
// RL22 - fault output ORs all unmasked flags
// RL23 - flags except gain reset latched unless latch disable set
// RL24 - mask bit disables its error flag
`timescale 1ns/10ps
`default_nettype none
`include "pgfc_defs.vh"

module pgfc_ctrl #(
    parameter [15:0] GAIN_RESET_CYCLES = `PGFC_IOVL_CYC
) (
    input  wire       clk_sys,
    input  wire       nrst,
    input  wire       clk_en,
    input  wire       spi_cs_n,
    input  wire       spi_sclk,
    input  wire       spi_mosi,
    output wire       spi_miso,
    output wire       spi_miso_oe,
    input  wire       out_overload_cond,
    input  wire       in_overload_cond,
    input  wire       mux_overvoltage_cond,
    input  wire       flag_latch_disable,
    input  wire       channel_exclusion_disable,
    input  wire [3:0] error_mask,
    input  wire       other_fault_flags,
    input  wire [6:0] gpio_in,
    output wire [6:0] gpio_out,
    output wire [6:0] gpio_oe,
    output wire [6:0] switch_closed,
    output wire [1:0] break_current_switch,
    output wire [1:0] break_current_select,
    output wire       gain_force_default,
    output wire       gain_reset_pulse,
    output wire       fault_int
);

    localparam [11:0] RESTORE_CYCLES = `PGFC_RESTORE_CYC;

    // next slot after ptr among enabled pins, lowest index first
    function [2:0] next_slot;
        input [2:0] ptr;
        input [6:0] en;
        integer i;
        begin
            next_slot = `PGFC_SLOT_SELF;
            for (i = 6; i >= 0; i = i - 1) begin
                if (en[i] && ((ptr == `PGFC_SLOT_SELF) || (i > ptr))) begin
                    next_slot = i[2:0];
                end
            end
        end
    endfunction

    // channel one wins when both pairs are asked for
    function [6:0] exclude;
        input [6:0] sw;
        input       dis;
        begin
            exclude = sw;
            if (!dis && (|sw[6:5]) && (|sw[4:3])) begin
                exclude[4:3] = 2'b00;
            end
        end
    endfunction

    // synchroniser chains: [0] first stage, [1] usable, [2] edge history
    reg [2:0]  cs_sync_reg;
    reg [2:0]  sclk_sync_reg;
    reg [1:0]  mosi_sync_reg;
    reg [1:0]  oovl_sync_reg;
    reg [1:0]  iovl_sync_reg;
    reg [1:0]  mov_sync_reg;
    reg [13:0] gpin_sync_reg;

    reg [4:0]  bit_cnt_reg;
    reg [14:0] shift_reg;
    reg [7:0]  hdr_reg;
    reg [7:0]  tx_reg;
    reg        miso_reg;

    reg [6:0]  pin_data_reg;
    reg [6:0]  input_sw_reg;
    reg [7:0]  wire_break_reg;
    reg [6:0]  pin_dir_reg;
    reg [6:0]  seq_map_reg;
    reg [2:0]  slot_reg;
    reg [6:0]  gpio_out_reg;
    reg [6:0]  switch_reg;

    reg        out_flag_reg;
    reg        in_flag_reg;
    reg        mov_flag_reg;
    reg        grst_flag_reg;
    reg        mux_open_reg;
    reg [11:0] restore_cnt_reg;
    reg [15:0] iovl_cnt_reg;
    reg        grst_pulse_reg;

    wire       cs_low    = ~cs_sync_reg[1];
    wire       cs_rise   = cs_sync_reg[1] & ~cs_sync_reg[2];
    wire       cs_fall   = ~cs_sync_reg[1] & cs_sync_reg[2];
    wire       sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
    wire       sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
    wire       self_sel  = (slot_reg == `PGFC_SLOT_SELF);
    wire       frame_act = cs_low & self_sel;
    wire       mosi_s    = mosi_sync_reg[1];
    wire [6:0] pin_s     = gpin_sync_reg[13:7];
    wire [6:0] seq_en    = seq_map_reg & pin_dir_reg;

    // header byte complete on this edge; msb set means read
    wire       hdr_done  = frame_act & sclk_rise & (bit_cnt_reg == `PGFC_HDR_BITS - 5'd1);
    wire [7:0] hdr_now   = {shift_reg[6:0], mosi_s};
    wire       wr_en     = frame_act & sclk_rise & ~hdr_reg[7]
                           & (bit_cnt_reg == `PGFC_FRAME_BITS - 5'd1);
    wire [6:0] wr_addr   = hdr_reg[6:0];
    wire [7:0] wr_data   = {shift_reg[6:0], mosi_s};

    wire       wr_analog = wr_en & (wr_addr == `PGFC_ADDR_ANALOG_ERR);
    wire [7:0] w1c       = wr_analog ? wr_data : 8'h00;
    wire       restore   = mux_open_reg & ~mov_sync_reg[1]
                           & (restore_cnt_reg == RESTORE_CYCLES - 12'd1);

    // read data mux; input pins report the sampled level
    reg [7:0] rd_data;
    always @* begin
        case (hdr_now[6:0])
            `PGFC_ADDR_ANALOG_ERR: rd_data = {grst_flag_reg, 4'h0, out_flag_reg,
                                              in_flag_reg, mov_flag_reg};
            // RL8 input pins read back
            `PGFC_ADDR_PIN_DATA:   rd_data = {1'b0, (pin_data_reg & pin_dir_reg)
                                              | (pin_s & ~pin_dir_reg)};
            `PGFC_ADDR_INPUT_SW:   rd_data = {1'b0, input_sw_reg};
            `PGFC_ADDR_WIRE_BREAK: rd_data = {wire_break_reg[7], 3'h0, wire_break_reg[3:0]};
            `PGFC_ADDR_PIN_DIR:    rd_data = {1'b0, pin_dir_reg};
            `PGFC_ADDR_SEQ_SELECT: rd_data = {1'b0, seq_map_reg};
            default:               rd_data = 8'h00;
        endcase
    end

    // two-flop synchronisers on every pin and analog level
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cs_sync_reg   <= 3'h7;
            sclk_sync_reg <= 3'h0;
            mosi_sync_reg <= 2'h0;
            oovl_sync_reg <= 2'h0;
            iovl_sync_reg <= 2'h0;
            mov_sync_reg  <= 2'h0;
            gpin_sync_reg <= 14'h0000;
        end else if (clk_en) begin
            cs_sync_reg   <= {cs_sync_reg[1:0], spi_cs_n};
            sclk_sync_reg <= {sclk_sync_reg[1:0], spi_sclk};
            mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi};
            oovl_sync_reg <= {oovl_sync_reg[0], out_overload_cond};
            iovl_sync_reg <= {iovl_sync_reg[0], in_overload_cond};
            mov_sync_reg  <= {mov_sync_reg[0], mux_overvoltage_cond};
            gpin_sync_reg <= {gpin_sync_reg[6:0], gpio_in};
        end
    end

    // serial frame: 8 header bits in, then 8 data bits in or out
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bit_cnt_reg <= 5'd0;
            shift_reg   <= 15'h0000;
            hdr_reg     <= 8'h00;
            tx_reg      <= 8'h00;
            miso_reg    <= 1'b0;
        end else if (clk_en) begin
            if (cs_fall) begin
                bit_cnt_reg <= 5'd0;
                miso_reg    <= 1'b0;
            end else if (frame_act && sclk_rise && bit_cnt_reg != `PGFC_FRAME_BITS) begin
                shift_reg   <= {shift_reg[13:0], mosi_s};
                bit_cnt_reg <= bit_cnt_reg + 5'd1;
                if (hdr_done) begin
                    hdr_reg <= hdr_now;
                    tx_reg  <= rd_data;
                end
            end else if (frame_act && sclk_fall && bit_cnt_reg >= `PGFC_HDR_BITS
                         && hdr_reg[7]) begin
                // data changes on the falling edge, msb first
                miso_reg <= tx_reg[7];
                tx_reg   <= {tx_reg[6:0], 1'b0};
            end
        end
    end

    // control registers written by the host
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pin_data_reg   <= `PGFC_RST_PIN_DATA;
            input_sw_reg   <= `PGFC_RST_INPUT_SW;
            wire_break_reg <= `PGFC_RST_WIRE_BREAK;
            pin_dir_reg    <= `PGFC_RST_PIN_DIR;
            seq_map_reg    <= `PGFC_RST_SEQ_SELECT;
        end else if (clk_en && wr_en) begin
            case (wr_addr)
                // RL8 writes to input bits ignored
                `PGFC_ADDR_PIN_DATA:   pin_data_reg <= (wr_data[6:0] & pin_dir_reg)
                                                       | (pin_data_reg & ~pin_dir_reg);
                // RL9 programmed switch image kept
                `PGFC_ADDR_INPUT_SW:   input_sw_reg <= wr_data[6:0];
                `PGFC_ADDR_WIRE_BREAK: wire_break_reg <= {wr_data[7], 3'h0, wr_data[3:0]};
                // RL17 direction per pin
                `PGFC_ADDR_PIN_DIR:    pin_dir_reg <= wr_data[6:0];
                `PGFC_ADDR_SEQ_SELECT: seq_map_reg <= wr_data[6:0];
                default:               pin_data_reg <= pin_data_reg;
            endcase
        end
    end

    // sequential chip select pointer; slot 7 is the device itself
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            slot_reg <= `PGFC_SLOT_SELF;
        end else if (clk_en) begin
            if (wr_en && wr_addr == `PGFC_ADDR_SEQ_SELECT) begin
                // RL20 restart via self
                slot_reg <= `PGFC_SLOT_SELF; // a mid-frame move would glitch a pin low
            end else if (cs_rise) begin
                // RL19 advance at pulse end
                slot_reg <= next_slot(slot_reg, seq_en);
            end
        end
    end

    // pin drivers and effective switch states, registered
    integer p;
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            gpio_out_reg <= 7'h7f & `PGFC_RST_PIN_DATA;
            switch_reg   <= `PGFC_RST_INPUT_SW;
        end else if (clk_en) begin
            for (p = 0; p < 7; p = p + 1) begin
                // RL18 chip select passes the host pulse
                if (seq_en[p]) begin
                    gpio_out_reg[p] <= (slot_reg == p[2:0]) ? cs_sync_reg[1] : 1'b1;
                end else begin
                    // RL7 plain data drive
                    gpio_out_reg[p] <= pin_data_reg[p];
                end
            end
            // RL4 overvoltage opens everything
            // RL10 pair exclusion
            // RL11 test path and RL12 short follow bits
            switch_reg <= mux_open_reg ? 7'h00
                          : exclude(input_sw_reg, channel_exclusion_disable);
        end
    end

    // overvoltage protect, restore timer and input overload timer
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mux_open_reg    <= 1'b0;
            restore_cnt_reg <= 12'd0;
            iovl_cnt_reg    <= 16'd0;
            grst_pulse_reg  <= 1'b0;
        end else if (clk_en) begin
            if (mov_sync_reg[1]) begin
                mux_open_reg    <= 1'b1;
                restore_cnt_reg <= 12'd0;
            end else if (restore) begin
                // RL5 reapply after 20 us in range
                mux_open_reg    <= 1'b0;
                restore_cnt_reg <= 12'd0;
            end else if (mux_open_reg) begin
                restore_cnt_reg <= restore_cnt_reg + 12'd1;
            end
            // RL3 one gain reset per long overload
            grst_pulse_reg <= iovl_sync_reg[1]
                              && (iovl_cnt_reg == GAIN_RESET_CYCLES - 16'd1);
            if (!iovl_sync_reg[1]) begin
                iovl_cnt_reg <= 16'd0;
            end else if (iovl_cnt_reg != GAIN_RESET_CYCLES) begin
                iovl_cnt_reg <= iovl_cnt_reg + 16'd1;
            end
        end
    end

    // error flags; a set in the clearing cycle wins
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            out_flag_reg  <= 1'b0;
            in_flag_reg   <= 1'b0;
            mov_flag_reg  <= 1'b0;
            grst_flag_reg <= 1'b0;
        end else if (clk_en) begin
            // RL23 transparent or latched
            // RL24 masked flags never set
            // RL1 output overload flag
            out_flag_reg <= ~error_mask[2] & (flag_latch_disable ? oovl_sync_reg[1]
                            : (oovl_sync_reg[1] | (out_flag_reg & ~w1c[`PGFC_BIT_OUT_OVL])));
            // RL2 input overload flag
            in_flag_reg  <= ~error_mask[1] & (flag_latch_disable ? iovl_sync_reg[1]
                            : (iovl_sync_reg[1] | (in_flag_reg & ~w1c[`PGFC_BIT_IN_OVL])));
            // RL6 nonlatched clears at restore
            mov_flag_reg <= ~error_mask[0] & (mov_sync_reg[1] | (mov_flag_reg
                            & ~(flag_latch_disable ? restore : w1c[`PGFC_BIT_MUX_OV])));
            // RL3 gain reset flag
            grst_flag_reg <= ~error_mask[3] & (grst_pulse_reg
                             | (grst_flag_reg & ~w1c[`PGFC_BIT_GAIN_RST]));
        end
    end

    assign spi_miso             = miso_reg;
    assign spi_miso_oe          = frame_act;
    // RL17 output enable per direction bit
    assign gpio_oe              = pin_dir_reg;
    assign gpio_out             = gpio_out_reg;
    assign switch_closed        = switch_reg;
    // RL13 both break switches may close
    assign break_current_switch = {wire_break_reg[`PGFC_BIT_WB_SW_FIRST],
                                   wire_break_reg[`PGFC_BIT_WB_SW_SECOND]};
    // RL16 code goes to both sources
    assign break_current_select = wire_break_reg[1:0];
    // RL14 force default gain; RL15 disable keeps it
    assign gain_force_default   = (wire_break_reg[`PGFC_BIT_WB_SW_FIRST]
                                   | wire_break_reg[`PGFC_BIT_WB_SW_SECOND])
                                  & ~wire_break_reg[`PGFC_BIT_WB_GAIN_DIS];
    assign gain_reset_pulse     = grst_pulse_reg;
    // RL22 fault is OR of unmasked flags
    assign fault_int            = out_flag_reg | in_flag_reg | mov_flag_reg
                                  | grst_flag_reg | other_fault_flags;

endmodule // pgfc_ctrl
`default_nettype wire

// >>> verification/pgfc_checker.sv
/* pgfc_checker: port-level assertions for pgfc_ctrl.
   assumes one clock domain and clk_en held high by the bench. */
`timescale 1ns/10ps
`default_nettype none
module pgfc_checker #(
    parameter [15:0] GAIN_RESET_CYCLES = 16'd50
) (
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire logic       out_overload_cond,
    input wire logic       in_overload_cond,
    input wire logic       mux_overvoltage_cond,
    input wire logic       channel_exclusion_disable,
    input wire logic [3:0] error_mask,
    input wire logic       other_fault_flags,
    input wire logic [6:0] gpio_oe,
    input wire logic [6:0] switch_closed,
    input wire logic [1:0] break_current_switch,
    input wire logic [1:0] break_current_select,
    input wire logic       gain_force_default,
    input wire logic       gain_reset_pulse,
    input wire logic       fault_int
);
    logic [11:0] quiet_cnt;
    logic [15:0] ovl_cnt;

    // cycles since overvoltage dropped; saturates so reset shows no history
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            quiet_cnt <= 12'hfff;
            ovl_cnt   <= 16'h0000;
        end else begin
            quiet_cnt <= mux_overvoltage_cond ? 12'h000 : quiet_cnt + {11'h000, quiet_cnt != 12'hfff};
            ovl_cnt   <= in_overload_cond ? ovl_cnt + {15'h0000, ovl_cnt != 16'hffff} : 16'h0000;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    AST_OV_OPEN: assert property (mux_overvoltage_cond [*8] |-> switch_closed == 7'h00)
        else $error("switches not opened under overvoltage");
    AST_OV_HOLD: assert property (quiet_cnt > 12'h000 && quiet_cnt < 12'd1990 |-> switch_closed == 7'h00)
        else $error("switches restored too early");
    AST_EXCL: assert property (!channel_exclusion_disable && !$past(channel_exclusion_disable) |-> !((|switch_closed[6:5]) && (|switch_closed[4:3])))
        else $error("both channel pairs closed");
    AST_GFORCE: assert property (gain_force_default |-> break_current_switch != 2'b00)
        else $error("gain forced without break switch");
    AST_GPULSE: assert property (gain_reset_pulse |-> ovl_cnt >= GAIN_RESET_CYCLES ##1 !gain_reset_pulse)
        else $error("gain reset pulse early or long");
    AST_RSTVAL: assert property ($rose(nrst) |-> switch_closed == 7'h60 && gpio_oe == 7'h00 && break_current_select == 2'b10)
        else $error("wrong outputs after reset");
    AST_OUT_FLAG: assert property ((out_overload_cond && !error_mask[2]) [*5] |-> fault_int)
        else $error("output overload not flagged");
    AST_MASK: assert property (&error_mask && $past(&error_mask) && !other_fault_flags |-> !fault_int)
        else $error("masked flags still raise fault");
    AST_OTHER: assert property (other_fault_flags |-> fault_int)
        else $error("other flags not merged into fault");

    // main scenarios reached
    COV_PULSE: cover property (gain_reset_pulse);
    COV_QUIET: cover property (quiet_cnt == 12'd1000 && switch_closed == 7'h00);
    COV_FORCE: cover property (gain_force_default);
endmodule // pgfc_checker
bind pgfc_ctrl pgfc_checker #(.GAIN_RESET_CYCLES(GAIN_RESET_CYCLES)) u_chk (.*);
`default_nettype wire

// >>> verification/pgfc_ctrl_tb.sv
/* pgfc_ctrl_tb: register-level tests of pgfc_ctrl through the host model.
   assumes the bind in the checker file and the defs header on the path. */
`timescale 1ns/10ps
`default_nettype none
`include "pgfc_defs.vh"
module pgfc_ctrl_tb;
    logic            clk_sys = 1'b0;
    logic            nrst = 1'b0;
    logic            clk_en = 1'b1;
    logic            out_overload_cond = 1'b0;
    logic            in_overload_cond = 1'b0;
    logic            mux_overvoltage_cond = 1'b0;
    logic            flag_latch_disable = 1'b0;
    logic            channel_exclusion_disable = 1'b0;
    logic [3:0]      error_mask = 4'h0;
    logic            other_fault_flags = 1'b0;
    logic [6:0]      gpio_in = 7'h2a;
    wire logic       spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe;
    wire logic       gain_force_default, gain_reset_pulse, fault_int;
    wire logic [6:0] gpio_out, gpio_oe, switch_closed;
    wire logic [1:0] break_current_switch, break_current_select;
    int              fail_count = 0, n_tests = 0, cycles = 0, pulses = 0;
    logic [6:0]      seen = 7'h00;
    logic [7:0]      rd;
    logic [7:0]      ra [6] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0b};
    logic [7:0]      rv [6] = '{8'h2a, 8'h60, 8'h02, 8'h00, 8'h00, 8'h00};
    logic [7:0]      sp [5] = '{8'h18, 8'h06, 8'h01, 8'h78, 8'h78};
    logic [7:0]      se [5] = '{8'h18, 8'h06, 8'h01, 8'h60, 8'h78};
    logic [7:0]      rp [5] = '{8'h01, 8'h04, 8'h00, 8'h01, 8'h04};
    logic [7:0]      re [5] = '{8'hff, 8'hff, 8'h0f, 8'hff, 8'hff};

    pgfc_ctrl #(.GAIN_RESET_CYCLES(16'd50)) DUT (.*);
    pgfc_host host (.*);

    always #5 clk_sys = ~clk_sys;

    // watchdog, pulse count, and chip-select pins seen low in a frame
    always @(negedge clk_sys) begin
        cycles++;
        if (gain_reset_pulse === 1'b1)
            pulses++;
        if (spi_cs_n === 1'b0)
            seen = seen | (~gpio_out & 7'h05);
        if (cycles == 40000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.xfer(1'b0, a[6:0], d, q);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        host.xfer(1'b1, a[6:0], 8'h00, q);
        check($sformatf("reg %h", a), exp, q);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        // reset state, input pin readback, unmapped address
        check("closed", 8'h60, {1'b0, switch_closed});
        check("current", 8'h02, {6'h00, break_current_select});
        check("oe", 8'h00, {1'b0, gpio_oe});
        foreach (ra[i]) rdchk(ra[i], rv[i]);
        $display("test reset done");
        // switch patterns, channel exclusion on then off
        foreach (sp[i]) begin
            channel_exclusion_disable = (i == 4);
            wr(8'h06, sp[i]);
            check("closed", se[i], {1'b0, switch_closed});
        end
        rdchk(8'h06, 8'h78);
        wr(8'h06, 8'h18);
        channel_exclusion_disable = 1'b0;
        $display("test switches done");
        // break current codes with both switches, then override disable
        for (int c = 0; c < 4; c++) begin
            wr(8'h07, 8'h0c | c[7:0]);
            check("current", c[7:0], {6'h00, break_current_select});
            check("break sw", 8'h03, {6'h00, break_current_switch});
            check("force", 8'h01, {7'h00, gain_force_default});
        end
        wr(8'h07, 8'h00);
        check("force", 8'h00, {7'h00, gain_force_default});
        check("break sw", 8'h00, {6'h00, break_current_switch});
        wr(8'h07, 8'h84);
        check("force", 8'h00, {7'h00, gain_force_default});
        $display("test wire break done");
        // overvoltage, latched then nonlatched flag
        for (int m = 0; m < 2; m++) begin
            flag_latch_disable = m[0];
            mux_overvoltage_cond = 1'b1;
            repeat (10) @(negedge clk_sys);
            check("ov open", 8'h00, {1'b0, switch_closed});
            mux_overvoltage_cond = 1'b0;
            rdchk(8'h06, 8'h18);
            rdchk(8'h04, 8'h01);
            repeat (2000) @(negedge clk_sys);
            check("restored", 8'h18, {1'b0, switch_closed});
            rdchk(8'h04, {7'h00, ~m[0]});
        end
        flag_latch_disable = 1'b0;
        wr(8'h04, 8'h01);
        $display("test overvoltage done");
        // output overload latched, masked, transparent, then write-one clear
        for (int k = 0; k < 3; k++) begin
            error_mask = (k == 1) ? 4'hf : 4'h0;
            flag_latch_disable = (k == 2);
            out_overload_cond = 1'b1;
            repeat (8) @(negedge clk_sys);
            out_overload_cond = 1'b0;
            rdchk(8'h04, (k == 0) ? 8'h04 : 8'h00);
            check("fault", (k == 0) ? 8'h01 : 8'h00, {7'h00, fault_int});
        end
        error_mask = 4'h0;
        flag_latch_disable = 1'b0;
        wr(8'h04, 8'h04);
        rdchk(8'h04, 8'h00);
        other_fault_flags = 1'b1;
        repeat (2) @(negedge clk_sys);
        check("fault", 8'h01, {7'h00, fault_int});
        other_fault_flags = 1'b0;
        // long input overload resets gain once
        pulses = 0;
        in_overload_cond = 1'b1;
        repeat (150) @(negedge clk_sys);
        in_overload_cond = 1'b0;
        check("pulses", 8'h01, pulses[7:0]);
        rdchk(8'h04, 8'h82);
        wr(8'h04, 8'h82);
        rdchk(8'h04, 8'h00);
        $display("test faults done");
        // pins: low four outputs, upper three inputs
        wr(8'h08, 8'h0f);
        wr(8'h05, 8'h55);
        check("oe", 8'h0f, {1'b0, gpio_oe});
        check("out", 8'h05, {4'h0, gpio_out[3:0]});
        rdchk(8'h05, 8'h25);
        $display("test pins done");
        // round robin over pins 0 and 2, then back to the device
        wr(8'h09, 8'h05);
        foreach (rp[i]) begin
            seen = 7'h00;
            host.xfer(1'b1, 7'h08, 8'h00, rd);
            check("cs pins", rp[i], {1'b0, seen});
            check("rr read", re[i], rd);
        end
        wr(8'h09, 8'h00);
        rdchk(8'h09, 8'h00);
        $display("test sequencer done");
        tally_and_finish();
    end
endmodule // pgfc_ctrl_tb
`default_nettype wire

// >>> verification/pgfc_host.sv
/* pgfc_host: behavioural host serial controller, mode 0, 16-bit frames.
   assumes the device's miso line is pulled up while released. */
`timescale 1ns/10ps
`default_nettype none
module pgfc_host (
    input wire logic clk_sys,
    output logic     spi_cs_n,
    output logic     spi_sclk,
    output logic     spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oe
);
    int cs_count = 0;

    // idle bus: deselected, clock parked low
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
    end

    // one frame; half period of five system clocks keeps the sync margin
    task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdat,
                        output logic [7:0] rdat);
        logic [15:0] word;
        word = {rd, addr, wdat};
        rdat = 8'h00;
        spi_cs_n = 1'b0;
        repeat (5) @(negedge clk_sys);
        for (int i = 15; i >= 0; i--) begin
            spi_mosi = word[i];
            repeat (5) @(negedge clk_sys);
            if (i < 8)
                rdat[i] = spi_miso_oe ? spi_miso : 1'b1;
            spi_sclk = 1'b1;
            repeat (5) @(negedge clk_sys);
            spi_sclk = 1'b0;
        end
        repeat (5) @(negedge clk_sys);
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        cs_count++;
        repeat (6) @(negedge clk_sys);
    endtask
endmodule // pgfc_host
`default_nettype wire
